// ### core/dma_irq_sources.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - There are eight channels 0 to 7, each with a done source and a half source.
// - A done request is high while the channel's done flag and done enable are both 1.
// - A half request is high while the channel's half flag and half enable are both 1.
// - Software writing a flag to 0 withdraws its request one clock after the flag clears.
// - Every request leaves on its own line, never merged with another.
// - In a channel the done request outranks the half request; channel 0 is listed first.
// - Only this controller may use 16-byte units; the CPU and table agent max 32 bits.
module dma_irq_sources #(
    parameter int CHANNELS = dma_irq_pkg::NUM_CHANNELS
) (
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // transfer events from the channel engines, same clock
    input wire logic [CHANNELS-1:0] DONE_EVENT,
    input wire logic [CHANNELS-1:0] HALF_EVENT,
    // per-channel requests to the interrupt controller
    output logic [CHANNELS-1:0] TRANSFER_DONE_IRQ,
    output logic [CHANNELS-1:0] HALF_DONE_IRQ,
    // summary interrupt of the status block
    output logic IRQ,
    // external bus access unit check
    input wire logic XREQ_VALID,
    input wire logic [1:0] XREQ_MASTER,
    input wire logic [2:0] XREQ_SIZE,
    output logic XREQ_GRANT,
    output logic XREQ_REFUSE
);
    // request lines and map are laid out for exactly eight channels
    if (CHANNELS != dma_irq_pkg::NUM_CHANNELS) begin : g_bad_channels
        $error("CHANNELS must be 8");
    end
    // the decoded window must hold the whole map and leave upper bits to check
    if (dma_irq_pkg::ADDR_W < 6 || dma_irq_pkg::ADDR_W > 31) begin : g_bad_window
        $error("ADDR_W must lie between 6 and 31");
    end
    // all four control fields must be readable through the mask
    if (dma_irq_pkg::CTRL_MASK[dma_irq_pkg::BIT_DONE_FLAG] != 1'b1 ||
            dma_irq_pkg::CTRL_MASK[dma_irq_pkg::BIT_HALF_FLAG] != 1'b1 ||
            dma_irq_pkg::CTRL_MASK[dma_irq_pkg::BIT_DONE_EN] != 1'b1 ||
            dma_irq_pkg::CTRL_MASK[dma_irq_pkg::BIT_HALF_EN] != 1'b1) begin : g_bad_fields
        $error("control fields fall outside the read mask");
    end

    localparam int ADDR_HI = dma_irq_pkg::ADDR_W - 1;
    logic [31:0] ctrl_q [CHANNELS];
    logic [1:0] ev_status_q;
    logic [1:0] ev_enable_q;
    logic [CHANNELS-1:0] done_irq_q;
    logic [CHANNELS-1:0] half_irq_q;
    logic irq_q;
    logic [31:0] rdata_q;
    logic [ADDR_HI:0] addr_q;
    logic wr_q;
    logic rd_take;
    logic wr_take;
    logic [CHANNELS-1:0] done_flag;
    logic [CHANNELS-1:0] half_flag;
    logic [CHANNELS-1:0] done_irq_d;
    logic [CHANNELS-1:0] half_irq_d;
    logic [31:0] rdata_d;
    logic [1:0] refused_ev;
    logic addr_in_range;
    logic word_size;
    logic bus_take;
    logic clear_hit;
    logic enable_hit;

    // writes outside the window or narrower than a word are dropped, not aliased
    assign addr_in_range = HADDR[31:dma_irq_pkg::ADDR_W] == '0;
    // bus size code of a word equals the word unit code
    assign word_size = HSIZE == dma_irq_pkg::UNIT_WORD;
    assign bus_take = HSEL && HREADY && HTRANS == dma_irq_pkg::HTRANS_NONSEQ;
    assign rd_take = bus_take && !HWRITE;
    assign wr_take = bus_take && HWRITE && addr_in_range && word_size;
    assign clear_hit = wr_q && addr_q == dma_irq_pkg::OFS_CLEAR;
    assign enable_hit = wr_q && addr_q == dma_irq_pkg::OFS_ENABLE;

    // address phase capture; the slave never stalls
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            addr_q <= '0;
            wr_q <= 1'b0;
        end else begin
            addr_q <= HADDR[ADDR_HI:0];
            wr_q <= wr_take;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            localparam logic [7:0] OFS = dma_irq_pkg::OFS_CTRL_BASE + 8'(ch * 4);
            logic hit;
            assign hit = wr_q && addr_q == OFS;
            assign done_flag[ch] = ctrl_q[ch][dma_irq_pkg::BIT_DONE_FLAG];
            assign half_flag[ch] = ctrl_q[ch][dma_irq_pkg::BIT_HALF_FLAG];
            // flags: hardware set wins over a software clear in the same cycle
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    ctrl_q[ch] <= dma_irq_pkg::CTRL_RESET;
                end else begin
                    if (hit) begin
                        // software may only clear a flag, never set one
                        ctrl_q[ch][dma_irq_pkg::BIT_DONE_EN] <= HWDATA[dma_irq_pkg::BIT_DONE_EN];
                        ctrl_q[ch][dma_irq_pkg::BIT_HALF_EN] <= HWDATA[dma_irq_pkg::BIT_HALF_EN];
                        if (!HWDATA[dma_irq_pkg::BIT_DONE_FLAG]) begin
                            ctrl_q[ch][dma_irq_pkg::BIT_DONE_FLAG] <= 1'b0;
                        end
                        if (!HWDATA[dma_irq_pkg::BIT_HALF_FLAG]) begin
                            ctrl_q[ch][dma_irq_pkg::BIT_HALF_FLAG] <= 1'b0;
                        end
                    end
                    if (DONE_EVENT[ch]) begin
                        ctrl_q[ch][dma_irq_pkg::BIT_DONE_FLAG] <= 1'b1;
                    end
                    if (HALF_EVENT[ch]) begin
                        ctrl_q[ch][dma_irq_pkg::BIT_HALF_FLAG] <= 1'b1;
                    end
                end
            end
            // level requests from flag and enable, one line each
            assign done_irq_d[ch] = done_flag[ch] && ctrl_q[ch][dma_irq_pkg::BIT_DONE_EN];
            assign half_irq_d[ch] = half_flag[ch] && ctrl_q[ch][dma_irq_pkg::BIT_HALF_EN];
        end
    endgenerate

    // separate registered lines, no arbitration between channels
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            done_irq_q <= '0;
            half_irq_q <= '0;
        end else begin
            done_irq_q <= done_irq_d;
            half_irq_q <= half_irq_d;
        end
    end
    assign TRANSFER_DONE_IRQ = done_irq_q;
    assign HALF_DONE_IRQ = half_irq_q;

    // sticky events: bit0 refused access unit, bit1 any done flag rising
    assign refused_ev = {|(DONE_EVENT & ~done_flag), XREQ_REFUSE};
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ev_status_q <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (refused_ev[i]) begin
                    ev_status_q[i] <= 1'b1;
                end else if (clear_hit && HWDATA[i]) begin
                    ev_status_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ev_enable_q <= '0;
        end else if (enable_hit) begin
            ev_enable_q <= HWDATA[1:0];
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(ev_status_q & ev_enable_q);
        end
    end
    assign IRQ = irq_q;

    // read data is registered in the address phase, ready in the data phase
    always_comb begin
        rdata_d = 32'h0000_0000;
        for (int i = 0; i < CHANNELS; i++) begin
            if (HADDR[ADDR_HI:0] == dma_irq_pkg::OFS_CTRL_BASE + 8'(i * 4)) begin
                rdata_d = ctrl_q[i] & dma_irq_pkg::CTRL_MASK;
            end
        end
        if (HADDR[ADDR_HI:0] == dma_irq_pkg::OFS_STATUS) begin
            rdata_d = {30'h0, ev_status_q};
        end else if (HADDR[ADDR_HI:0] == dma_irq_pkg::OFS_ENABLE) begin
            rdata_d = {30'h0, ev_enable_q};
        end else if (HADDR[ADDR_HI:0] == dma_irq_pkg::OFS_EVENT) begin
            rdata_d = {16'h0, half_irq_q, done_irq_q};
        end else if (HADDR[ADDR_HI:0] == dma_irq_pkg::OFS_WIDTH) begin
            rdata_d = {29'h0, dma_irq_pkg::UNIT_16BYTE};
        end
        if (!addr_in_range) begin
            rdata_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_take) begin
            rdata_q <= rdata_d;
        end
    end
    assign HRDATA = rdata_q;

    // 16-byte units reserved for this controller
    access_unit_check u_unit (
        .clk(CLK),
        .arst_n(ARST_N),
        .req_valid(XREQ_VALID),
        .req_master(XREQ_MASTER),
        .req_size(XREQ_SIZE),
        .grant_q(XREQ_GRANT),
        .refuse_q(XREQ_REFUSE)
    );
endmodule
`default_nettype wire

// ### core/dma_irq_pkg.sv
package dma_irq_pkg;
    localparam int NUM_CHANNELS = 8;
    localparam int ADDR_W = 8;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL_BASE = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_CLEAR = 8'h24;
    localparam logic [7:0] OFS_ENABLE = 8'h28;
    localparam logic [7:0] OFS_EVENT = 8'h2C;
    localparam logic [7:0] OFS_WIDTH = 8'h30;
    // per-channel control register fields
    localparam int BIT_DONE_FLAG = 0;
    localparam int BIT_HALF_FLAG = 1;
    localparam int BIT_DONE_EN = 2;
    localparam int BIT_HALF_EN = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_000F;
    // access units
    localparam logic [2:0] UNIT_16BYTE = 3'h4;
    localparam logic [2:0] UNIT_WORD = 3'h2;
    localparam logic [1:0] REQ_CPU = 2'h0;
    localparam logic [1:0] REQ_TABLE = 2'h1;
    localparam logic [1:0] REQ_DMA = 2'h2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ### core/access_unit_check.sv
`timescale 1ns/1ps
`default_nettype none
// limits external bus access units per requesting master
module access_unit_check (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // request
    input wire logic req_valid,
    input wire logic [1:0] req_master,
    input wire logic [2:0] req_size,
    // verdict
    output logic grant_q,
    output logic refuse_q
);
    logic too_wide;
    always_comb begin
        too_wide = 1'b0;
        if (req_size > dma_irq_pkg::UNIT_16BYTE) begin
            too_wide = 1'b1;
        end else if (req_master != dma_irq_pkg::REQ_DMA &&
                     req_size > dma_irq_pkg::UNIT_WORD) begin
            too_wide = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            grant_q <= 1'b0;
            refuse_q <= 1'b0;
        end else begin
            grant_q <= req_valid && !too_wide;
            refuse_q <= req_valid && too_wide;
        end
    end
endmodule
`default_nettype wire

// ### sim/dma_irq_sources_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dma_irq_sources_chk #(
    parameter int CHANNELS = 8
) (
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // bus
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    // events and requests
    input wire logic [CHANNELS-1:0] DONE_EVENT,
    input wire logic [CHANNELS-1:0] HALF_EVENT,
    input wire logic [CHANNELS-1:0] TRANSFER_DONE_IRQ,
    input wire logic [CHANNELS-1:0] HALF_DONE_IRQ,
    // access check
    input wire logic XREQ_VALID,
    input wire logic [1:0] XREQ_MASTER,
    input wire logic [2:0] XREQ_SIZE,
    input wire logic XREQ_GRANT,
    input wire logic XREQ_REFUSE
);
    logic [2:0] quiet_q;
    wire act = (HSEL && HREADY && HTRANS == 2'h2 && HWRITE) || (|DONE_EVENT) || (|HALF_EVENT);
    // writes reach the lines two edges on, events one: four quiet edges leaves margin
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            quiet_q <= 3'h0;
        end else if (act) begin
            quiet_q <= 3'h0;
        end else if (quiet_q != 3'h7) begin
            quiet_q <= quiet_q + 3'h1;
        end
    end
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);
    AST_DMA_WIDE: assert property (XREQ_VALID && XREQ_MASTER == 2'h2 && XREQ_SIZE == 3'h4
        |=> XREQ_GRANT && !XREQ_REFUSE) else $error("wide dma unit not granted");
    AST_NARROW_ONLY: assert property (XREQ_VALID && XREQ_MASTER != 2'h2 && XREQ_SIZE > 3'h2
        |=> XREQ_REFUSE && !XREQ_GRANT) else $error("wide unit not refused");
    AST_WORD_OK: assert property (XREQ_VALID && XREQ_SIZE <= 3'h2 |=> XREQ_GRANT)
        else $error("word unit not granted");
    AST_NO_VERDICT: assert property (!XREQ_VALID |=> !XREQ_GRANT && !XREQ_REFUSE)
        else $error("verdict without request");
    AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
        else $error("bus not ready or not okay");
    AST_LEVEL_HOLD: assert property (quiet_q >= 3'h4
        |-> $stable(TRANSFER_DONE_IRQ) && $stable(HALF_DONE_IRQ)) else $error("line moved idle");
    AST_DONE_CAUSE: assert property ((TRANSFER_DONE_IRQ & ~$past(TRANSFER_DONE_IRQ)) != '0
        |-> quiet_q < 3'h4) else $error("done line rose without cause");
    AST_HALF_CAUSE: assert property ((HALF_DONE_IRQ & ~$past(HALF_DONE_IRQ)) != '0
        |-> quiet_q < 3'h4) else $error("half line rose without cause");
endmodule
bind dma_irq_sources dma_irq_sources_chk #(.CHANNELS(CHANNELS)) u_chk (
    .CLK(CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DONE_EVENT(DONE_EVENT),
    .HALF_EVENT(HALF_EVENT), .TRANSFER_DONE_IRQ(TRANSFER_DONE_IRQ),
    .HALF_DONE_IRQ(HALF_DONE_IRQ), .XREQ_VALID(XREQ_VALID), .XREQ_MASTER(XREQ_MASTER),
    .XREQ_SIZE(XREQ_SIZE), .XREQ_GRANT(XREQ_GRANT), .XREQ_REFUSE(XREQ_REFUSE)
);
`default_nettype wire

// ### sim/irq_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_model (
    // one line per request
    input wire logic [7:0] done_req,
    input wire logic [7:0] half_req,
    // chosen source
    output logic pending,
    output logic [4:0] winner
);
    // default ranking: lower channel first, done ahead of half
    always_comb begin
        pending = 1'b0;
        winner = 5'h00;
        for (int i = 7; i >= 0; i--) begin
            if (half_req[i]) begin
                pending = 1'b1;
                winner = 5'(2 * i + 1);
            end
            if (done_req[i]) begin
                pending = 1'b1;
                winner = 5'(2 * i);
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/dma_irq_sources_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dma_irq_sources_tb;
    logic CLK, ARST_N, HSEL, HWRITE, HREADYOUT, HRESP, IRQ, XREQ_VALID, XREQ_GRANT, XREQ_REFUSE;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    logic [1:0] HTRANS, XREQ_MASTER;
    logic [2:0] XREQ_SIZE;
    logic [7:0] DONE_EVENT, HALF_EVENT, TRANSFER_DONE_IRQ, HALF_DONE_IRQ;
    logic pending;
    logic [4:0] winner;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;
    dma_irq_sources u_dma_irq_sources (.CLK(CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DONE_EVENT(DONE_EVENT),
        .HALF_EVENT(HALF_EVENT), .TRANSFER_DONE_IRQ(TRANSFER_DONE_IRQ),
        .HALF_DONE_IRQ(HALF_DONE_IRQ), .IRQ(IRQ), .XREQ_VALID(XREQ_VALID),
        .XREQ_MASTER(XREQ_MASTER), .XREQ_SIZE(XREQ_SIZE), .XREQ_GRANT(XREQ_GRANT),
        .XREQ_REFUSE(XREQ_REFUSE));
    irq_ctrl_model u_irq_ctrl_model (.done_req(TRANSFER_DONE_IRQ), .half_req(HALF_DONE_IRQ),
        .pending(pending), .winner(winner));
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // run takes about 330 cycles
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 6000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge CLK);
        HSEL <= 1'b1;
        HTRANS <= dma_irq_pkg::HTRANS_NONSEQ;
        HADDR <= {24'h000000, a};
        HWRITE <= wr;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
        chk("resp", {31'h0, HRESP}, 32'h0);
    endtask
    task automatic settle();
        @(posedge CLK);
        #1;
    endtask
    task automatic pulse(input int c, input logic half);
        @(posedge CLK);
        DONE_EVENT <= half ? 8'h00 : 8'h01 << c;
        HALF_EVENT <= half ? 8'h01 << c : 8'h00;
        @(posedge CLK);
        DONE_EVENT <= 8'h00;
        HALF_EVENT <= 8'h00;
    endtask
    task automatic lines(input logic [31:0] exp);
        settle();
        chk("lines", {16'h0000, HALF_DONE_IRQ, TRANSFER_DONE_IRQ}, exp);
    endtask
    task automatic xreq(input logic [1:0] m, input logic [2:0] s);
        logic g;
        @(posedge CLK);
        XREQ_VALID <= 1'b1;
        XREQ_MASTER <= m;
        XREQ_SIZE <= s;
        @(posedge CLK);
        XREQ_VALID <= 1'b0;
        #1;
        g = (s <= 3'h2) || (m == 2'h2 && s <= 3'h4);
        chk("verdict", {30'h0, XREQ_GRANT, XREQ_REFUSE}, {30'h0, g, !g});
    endtask
    initial begin
        {ARST_N, HSEL, HWRITE, XREQ_VALID} = 4'h0;
        {HADDR, HWDATA} = 64'h0;
        {HTRANS, XREQ_MASTER, XREQ_SIZE} = 7'h00;
        {DONE_EVENT, HALF_EVENT} = 16'h0000;
        repeat (16) @(posedge CLK);
        ARST_N <= 1'b1;
        lines(32'h0);
        bus(1'b0, 8'h30, 32'h0);
        chk("unit", rd, 32'h4);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", rd, 32'h0);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, 8'(4 * c), 32'hC);
            pulse(c, 1'b0);
            lines(32'h1 << c);
            pulse(c, 1'b1);
            lines(32'h101 << c);
            chk("winner", {27'h0, winner}, 32'(2 * c));
            bus(1'b0, 8'(4 * c), 32'h0);
            chk("ctrl", rd, 32'hF);
            bus(1'b0, 8'h2C, 32'h0);
            chk("line reg", rd, 32'h101 << c);
            bus(1'b1, 8'(4 * c), 32'hE);
            lines(32'h100 << c);
            chk("winner", {27'h0, winner}, 32'(2 * c + 1));
            bus(1'b1, 8'(4 * c), 32'h6);
            lines(32'h0);
            bus(1'b1, 8'(4 * c), 32'hE);
            lines(32'h100 << c);
            bus(1'b1, 8'(4 * c), 32'h0);
            lines(32'h0);
        end
        $display("test channels done");
        bus(1'b0, 8'h20, 32'h0);
        chk("new done", rd, 32'h2);
        bus(1'b1, 8'h24, 32'hFFFFFFFF);
        bus(1'b1, 8'h28, 32'h0);
        for (int m = 0; m < 3; m++) begin
            for (int s = 0; s < 6; s++) begin
                xreq(2'(m), 3'(s));
            end
        end
        bus(1'b0, 8'h20, 32'h0);
        chk("status", rd, 32'h1);
        chk("masked", {31'h0, IRQ}, 32'h0);
        bus(1'b1, 8'h28, 32'h1);
        settle();
        chk("irq", {31'h0, IRQ}, 32'h1);
        bus(1'b1, 8'h24, 32'h1);
        settle();
        chk("cleared", {31'h0, IRQ}, 32'h0);
        $display("test access and status done");
        give_verdict();
    end
endmodule
`default_nettype wire
